/* File: include/cal_pkg.sv */
// shared constants and types of the calibration and eeprom command link
// Overview of operation
// [RQ1] frequency autocal rewrites only frequency gain
// [RQ2] gain times expected over measured, range-checked
// [RQ3] host applies reference frequency before autocal
// [RQ4] host saves only after autocal acknowledged; the HOP_RESTORE order saves without one
// [RQ5] outputs scaled by one plus c*(T-Tcal)
// [RQ6] coefficient is signed register over 2^M
// [RQ7] M is 26 frequency, 27 others
// [RQ8] three coefficient registers, power shared
// [RQ9] temperature operand is 10-bit thermistor value
// [RQ10] host copies thermistor reading into reference
// [RQ11] delimiter A5A5, save, reset restores factory
// [RQ12] eeprom 256 words in 32 pages
// [RQ13] page read 0x42: ack, data, checksum
// [RQ14] page write 0x50, 18 bytes, ack
// [RQ15] bulk erase 0x4F erases all, ack
// [RQ16] 16-bit frequency, zero in dc mode
// [RQ17] erased reads FFFF, page above 31 nak
package cal_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [15:0] word_t;
	// ********************************
	// command codes and answers
	// ********************************
	localparam byte_t CMD_PAGE_RD = 8'h42;
	localparam byte_t CMD_PAGE_WR = 8'h50;
	localparam byte_t CMD_ERASE = 8'h4F;
	localparam byte_t CMD_AUTO_FREQ = 8'h76;
	localparam byte_t CMD_SAVE = 8'h53;
	localparam byte_t CMD_WR_WORD = 8'h4D;
	localparam byte_t CMD_RD_WORD = 8'h4E;
	localparam byte_t RSP_ACK = 8'h06;
	localparam byte_t RSP_NAK = 8'h15;
	localparam byte_t HOP_TCAL = 8'h01;
	localparam byte_t HOP_RESTORE = 8'h02;
	// ********************************
	// calibration constants
	// ********************************
	localparam word_t DELIM_FACTORY = 16'hA5A5;
	localparam logic [31:0] GAIN_MIN = 32'd25000;
	localparam logic [31:0] GAIN_MAX = 32'd65535;
	localparam int M_FREQ = 26;
	localparam int M_OTHER = 27;
	localparam word_t COEF_RESET = 16'h0000;
	localparam word_t TCAL_RESET = 16'h0000;
	localparam logic [4:0] DIV_LAST = 5'd31;
	// ********************************
	// device register indices
	// ********************************
	localparam byte_t REG_COEF_F = 8'h00;
	localparam byte_t REG_COEF_I = 8'h01;
	localparam byte_t REG_COEF_P = 8'h02;
	localparam byte_t REG_TCAL = 8'h03;
	localparam byte_t REG_DELIM = 8'h04;
	localparam byte_t REG_FREF = 8'h05;
	localparam byte_t REG_GAIN = 8'h06;
	localparam byte_t REG_THERM = 8'h07;
	localparam byte_t REG_LAST_RD = 8'h0B;
	// ********************************
	// eeprom geometry
	// ********************************
	localparam int WORDS = 256;
	localparam int PAGES = 32;
	localparam logic [8:0] ERASE_LAST = 9'd255;
	localparam logic [8:0] PAGE_WORD_LAST = 9'd7;
	localparam word_t ERASED = 16'hFFFF;
	// ********************************
	// host register offsets
	// ********************************
	localparam logic [7:0] OFS_CMD = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_DATA0 = 8'h08;
	localparam logic [7:0] OFS_DATA3 = 8'h14;
endpackage

/* File: include/cal_link_if.sv */
// byte-stream command link between host and power monitor
`timescale 1ns/1ps
interface cal_link_if;
	logic h2d_valid;
	logic h2d_ready;
	cal_pkg::byte_t h2d_data;
	logic d2h_valid;
	logic d2h_ready;
	cal_pkg::byte_t d2h_data;
	modport dev(input h2d_valid, input h2d_data, output h2d_ready,
		output d2h_valid, output d2h_data, input d2h_ready);
	modport host(output h2d_valid, output h2d_data, input h2d_ready,
		input d2h_valid, input d2h_data, output d2h_ready);
endinterface

/* File: rtl/calib_eeprom_cmd_handler.sv */
// power monitor end: command interpreter, calibration, compensation, eeprom
//
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module calib_eeprom_cmd_handler #(
	parameter cal_pkg::word_t GAIN_FACTORY = 16'h8000,
	parameter cal_pkg::word_t FREF_RESET = 16'h1770
) (
	input wire logic core_clk,
	input wire logic reset_n,
	cal_link_if.dev link,
	input wire cal_pkg::word_t freq_raw,
	input wire cal_pkg::word_t irms_raw,
	input wire cal_pkg::word_t pact_raw,
	input wire cal_pkg::word_t preact_raw,
	input wire logic [9:0] therm_adc,
	input wire logic dc_mode,
	input wire cal_pkg::word_t flash_gain,
	input wire cal_pkg::word_t flash_delim,
	output cal_pkg::word_t freq_out,
	output cal_pkg::word_t irms_out,
	output cal_pkg::word_t pact_out,
	output cal_pkg::word_t preact_out,
	output logic flash_save,
	output cal_pkg::word_t save_gain,
	output cal_pkg::word_t save_delim
);
	import cal_pkg::*;

	typedef enum logic [2:0] {
		S_BOOT = 3'b000,
		S_OP = 3'b001,
		S_ARG = 3'b010,
		S_EXEC = 3'b011,
		S_RSP = 3'b100
	} dev_state_t;

	typedef struct packed {
		dev_state_t st;
		byte_t op;
		logic [4:0] cnt;
		logic [4:0] need;
		logic [4:0] last;
		logic [16:0][7:0] arg;
		byte_t tx;
		byte_t sum;
		logic [31:0] quo;
		logic [16:0] rem;
		word_t dvs;
		logic [8:0] ecnt;
		word_t gain;
		word_t coef_f;
		word_t coef_i;
		word_t coef_p;
		word_t tcal;
		word_t delim;
		word_t fref;
		word_t rword;
		logic [3:0][15:0] comp;
		logic save;
	} dev_reg_t;

	dev_reg_t q;
	dev_reg_t d;
	// eeprom cells keep no reset: contents survive a core reset
	word_t mem [WORDS];

	// ********************************
	// temperature compensation
	// ********************************
	logic [31:0] freq_prod;
	word_t freq_x;
	logic signed [10:0] dt;
	logic [3:0][15:0] xin;
	logic [3:0][15:0] yout;

	assign freq_prod = freq_raw * q.gain;
	assign freq_x = freq_prod[30:15];
	assign dt = signed'({1'b0, therm_adc}) - signed'({1'b0, q.tcal[9:0]}); // [RQ9]
	assign xin = {preact_raw, pact_raw, irms_raw, freq_x};

	for (genvar c = 0; c < 4; c++)
	begin : g_comp
		localparam int MSH = (c == 0) ? M_FREQ : M_OTHER; // [RQ7]
		logic signed [17:0] xs;
		logic signed [15:0] cf;
		logic signed [46:0] prod;
		logic signed [47:0] y;
		assign xs = (c >= 2) ? 18'(signed'(xin[c])) : signed'({2'b00, xin[c]});
		assign cf = (c == 0) ? q.coef_f : ((c == 1) ? q.coef_i : q.coef_p); // [RQ8]
		assign prod = xs * cf * dt;
		assign y = 48'(xs) + 48'(prod >>> MSH); // [RQ5] [RQ6]
		// results clip rather than wrap at the output range
		if (c >= 2)
		begin : g_signed
			assign yout[c] = (y > 48'sd32767) ? 16'h7FFF :
				((y < -48'sd32768) ? 16'h8000 : y[15:0]);
		end
		else
		begin : g_unsigned
			assign yout[c] = (y < 48'sd0) ? 16'h0000 :
				((y > 48'sd65535) ? 16'hFFFF : y[15:0]);
		end
	end

	// ********************************
	// command sequencer
	// ********************************
	function automatic logic [4:0] arg_len(input byte_t op);
		unique case (op)
			CMD_PAGE_RD, CMD_RD_WORD: arg_len = 5'd1;
			CMD_PAGE_WR: arg_len = 5'd17; // [RQ14]
			CMD_WR_WORD: arg_len = 5'd3;
			default: arg_len = 5'd0; // [RQ15]
		endcase
	endfunction

	logic page_ok;
	logic [3:0] kidx;
	word_t mem_rd;
	logic mem_we;
	logic [7:0] mem_wa;
	word_t mem_wd;
	logic is_erase;

	assign page_ok = (q.arg[0] < 8'(PAGES)); // [RQ17]
	assign kidx = q.cnt[3:0];
	assign mem_rd = mem[{q.arg[0][4:0], kidx[3:1]}]; // [RQ12]
	assign is_erase = (q.op == CMD_ERASE);
	assign mem_we = (q.st == S_EXEC) && (is_erase || ((q.op == CMD_PAGE_WR) && page_ok));
	assign mem_wa = is_erase ? q.ecnt[7:0] : {q.arg[0][4:0], q.ecnt[2:0]};
	assign mem_wd = is_erase ? ERASED : // [RQ15] [RQ17]
		{q.arg[5'({q.ecnt[2:0], 1'b1})], q.arg[5'({q.ecnt[2:0], 1'b1}) + 5'd1]};

	always_comb
	begin
		logic fin;
		logic ok;
		logic [4:0] len;
		logic [17:0] r;
		byte_t s;
		fin = 1'b0;
		ok = 1'b0;
		len = 5'd1;
		r = 18'd0;
		s = 8'h00;
		d = q;
		d.save = 1'b0;
		d.comp = yout;
		if (dc_mode)
		begin
			d.comp[0] = 16'h0000; // [RQ16]
		end
		unique case (q.st)
			S_BOOT:
			begin
				// a stored delimiter of A5A5 selects factory gain after reset
				d.gain = (flash_delim == DELIM_FACTORY) ? GAIN_FACTORY : flash_gain; // [RQ11]
				d.delim = flash_delim;
				d.st = S_OP;
			end
			S_OP:
			begin
				if (link.h2d_valid)
				begin
					d.op = link.h2d_data;
					d.need = arg_len(link.h2d_data);
					d.cnt = 5'd0;
					d.ecnt = 9'd0;
					d.quo = q.gain * q.fref; // [RQ2]
					d.rem = 17'd0;
					d.dvs = freq_x;
					d.st = (arg_len(link.h2d_data) == 5'd0) ? S_EXEC : S_ARG;
				end
			end
			S_ARG:
			begin
				if (link.h2d_valid)
				begin
					d.arg[q.cnt] = link.h2d_data;
					d.cnt = q.cnt + 5'd1;
					if (q.cnt + 5'd1 == q.need)
					begin
						d.st = S_EXEC;
					end
				end
			end
			S_EXEC:
			begin
				d.ecnt = q.ecnt + 9'd1;
				if (q.op == CMD_PAGE_RD)
				begin
					fin = 1'b1;
					ok = page_ok;
					len = 5'd18; // [RQ13]
				end
				else if (q.op == CMD_PAGE_WR)
				begin
					fin = !page_ok || (q.ecnt == PAGE_WORD_LAST);
					ok = page_ok; // [RQ14]
				end
				else if (q.op == CMD_ERASE)
				begin
					fin = (q.ecnt == ERASE_LAST);
					ok = 1'b1; // [RQ15]
				end
				else if (q.op == CMD_AUTO_FREQ)
				begin
					// one quotient bit per cycle keeps the divider small
					r = {q.rem, q.quo[31]};
					d.quo = {q.quo[30:0], (r[16:0] >= {1'b0, q.dvs})};
					d.rem = (r[16:0] >= {1'b0, q.dvs}) ? r[16:0] - {1'b0, q.dvs} : r[16:0];
					fin = (q.dvs == 16'h0000) || (q.ecnt[4:0] == DIV_LAST);
					ok = (q.dvs != 16'h0000) && (d.quo >= GAIN_MIN) && (d.quo <= GAIN_MAX); // [RQ2]
					if (fin && ok)
					begin
						d.gain = d.quo[15:0]; // [RQ1]
					end
				end
				else if (q.op == CMD_SAVE)
				begin
					d.save = 1'b1; // [RQ11]
					fin = 1'b1;
					ok = 1'b1;
				end
				else if (q.op == CMD_WR_WORD)
				begin
					fin = 1'b1;
					ok = (q.arg[0] <= REG_GAIN);
					unique case (q.arg[0])
						REG_COEF_F: d.coef_f = {q.arg[1], q.arg[2]};
						REG_COEF_I: d.coef_i = {q.arg[1], q.arg[2]};
						REG_COEF_P: d.coef_p = {q.arg[1], q.arg[2]};
						REG_TCAL: d.tcal = {q.arg[1], q.arg[2]};
						REG_DELIM: d.delim = {q.arg[1], q.arg[2]};
						REG_FREF: d.fref = {q.arg[1], q.arg[2]};
						REG_GAIN: d.gain = {q.arg[1], q.arg[2]};
						default: d.gain = q.gain;
					endcase
				end
				else if (q.op == CMD_RD_WORD)
				begin
					fin = 1'b1;
					ok = (q.arg[0] <= REG_LAST_RD);
					len = 5'd4;
					unique case (q.arg[0])
						REG_COEF_F: d.rword = q.coef_f;
						REG_COEF_I: d.rword = q.coef_i;
						REG_COEF_P: d.rword = q.coef_p;
						REG_TCAL: d.rword = q.tcal;
						REG_DELIM: d.rword = q.delim;
						REG_FREF: d.rword = q.fref;
						REG_GAIN: d.rword = q.gain;
						REG_THERM: d.rword = {6'h00, therm_adc};
						default: d.rword = q.comp[q.arg[0][1:0]];
					endcase
				end
				else
				begin
					fin = 1'b1;
				end
				if (fin)
				begin
					d.st = S_RSP;
					d.cnt = 5'd0;
					d.sum = 8'h00;
					d.last = ok ? len - 5'd1 : 5'd0;
					d.tx = ok ? RSP_ACK : RSP_NAK;
				end
			end
			S_RSP:
			begin
				if (link.d2h_ready)
				begin
					s = q.sum + q.tx;
					d.sum = s;
					d.cnt = q.cnt + 5'd1;
					if (q.cnt == q.last)
					begin
						d.st = S_OP;
					end
					else if (q.cnt + 5'd1 == q.last)
					begin
						d.tx = s; // [RQ13]
					end
					else if (q.op == CMD_PAGE_RD)
					begin
						d.tx = kidx[0] ? mem_rd[7:0] : mem_rd[15:8];
					end
					else
					begin
						d.tx = (q.cnt == 5'd0) ? q.rword[15:8] : q.rword[7:0];
					end
				end
			end
			default:
			begin
				d.st = S_OP;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			q <= '0;
			q.st <= S_BOOT;
			q.coef_f <= COEF_RESET;
			q.coef_i <= COEF_RESET;
			q.coef_p <= COEF_RESET;
			q.tcal <= TCAL_RESET;
			q.fref <= FREF_RESET;
			q.gain <= GAIN_FACTORY;
		end
		else
		begin
			q <= d;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (mem_we)
		begin
			mem[mem_wa] <= mem_wd;
		end
	end

	assign link.h2d_ready = (q.st == S_OP) || (q.st == S_ARG);
	assign link.d2h_valid = (q.st == S_RSP);
	assign link.d2h_data = q.tx;
	assign freq_out = q.comp[0];
	assign irms_out = q.comp[1];
	assign pact_out = q.comp[2];
	assign preact_out = q.comp[3];
	assign flash_save = q.save;
	assign save_gain = q.gain;
	assign save_delim = q.delim;
endmodule

/* File: rtl/calib_host_ctrl.sv */
// host end: axi4-lite order registers driving the command link
`timescale 1ns/1ps
module calib_host_ctrl #(
	parameter int ADDR_W = 8
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic awvalid,
	output logic awready,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [ADDR_W-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire logic ref_applied,
	cal_link_if.host link
);
	import cal_pkg::*;

	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_TX = 2'b01,
		H_RX = 2'b10
	} host_state_t;

	typedef struct packed {
		host_state_t st;
		byte_t code;
		byte_t a1;
		word_t wdat;
		byte_t mac;
		logic phase;
		logic [4:0] idx;
		logic [4:0] last;
		byte_t tx;
		byte_t sum;
		logic [15:0][7:0] buff;
		logic ack;
		logic refused;
		logic cks_bad;
		logic cal_ok;
		logic aw_got;
		logic w_got;
		logic [ADDR_W-1:0] wa;
		logic [31:0] wd;
		logic [3:0] ws;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} host_reg_t;

	host_reg_t q;
	host_reg_t d;

	function automatic logic [4:0] tx_last(input byte_t c);
		unique case (c)
			CMD_PAGE_RD, CMD_RD_WORD: tx_last = 5'd1; // [RQ13]
			CMD_PAGE_WR: tx_last = 5'd17; // [RQ14]
			CMD_WR_WORD: tx_last = 5'd3;
			default: tx_last = 5'd0; // [RQ15]
		endcase
	endfunction

	function automatic logic [4:0] rx_last(input byte_t c);
		unique case (c)
			CMD_PAGE_RD: rx_last = 5'd17;
			CMD_RD_WORD: rx_last = 5'd3;
			default: rx_last = 5'd0;
		endcase
	endfunction

	// ********************************
	// order sequencer and bus slave
	// ********************************
	always_comb
	begin
		logic done;
		logic [4:0] n;
		byte_t b;
		logic [5:0] wi;
		done = 1'b0;
		n = q.idx + 5'd1;
		b = link.d2h_data;
		wi = q.wa[7:2];
		d = q;
		if (q.bvalid && bready)
		begin
			d.bvalid = 1'b0;
		end
		if (q.rvalid && rready)
		begin
			d.rvalid = 1'b0;
		end
		if (awvalid && awready)
		begin
			d.aw_got = 1'b1;
			d.wa = awaddr;
		end
		if (wvalid && wready)
		begin
			d.w_got = 1'b1;
			d.wd = wdata;
			d.ws = wstrb;
		end
		if (arvalid && arready)
		begin
			d.rvalid = 1'b1;
			d.rresp = 2'b00;
			d.rdata = 32'h0000_0000;
			if (araddr == ADDR_W'(OFS_CMD))
			begin
				d.rdata = {q.wdat, q.a1, q.code};
			end
			else if (araddr == ADDR_W'(OFS_STAT))
			begin
				d.rdata = {27'h0, q.cal_ok, q.cks_bad, q.refused, q.ack, q.st != H_IDLE};
			end
			else if (araddr >= ADDR_W'(OFS_DATA0) && araddr <= ADDR_W'(OFS_DATA3)
				&& araddr[1:0] == 2'b00)
			begin
				d.rdata = q.buff[4'({araddr[3:2] - 2'd2, 2'b00}) +: 4];
				d.rdata = {d.rdata[7:0], d.rdata[15:8], d.rdata[23:16], d.rdata[31:24]};
			end
			else
			begin
				d.rresp = 2'b10;
			end
		end
		if (q.aw_got && q.w_got && !q.bvalid)
		begin
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = 2'b00;
			if (q.wa == ADDR_W'(OFS_CMD))
			begin
				if (q.st != H_IDLE)
				begin
					d.refused = 1'b1;
				end
				else if ((q.wd[7:0] == CMD_AUTO_FREQ && !ref_applied) // [RQ3]
					|| (q.wd[7:0] == CMD_SAVE && !q.cal_ok)) // [RQ4]
				begin
					d.refused = 1'b1;
				end
				else
				begin
					d.refused = 1'b0;
					d.phase = 1'b0;
					d.mac = q.wd[7:0];
					d.st = H_TX;
					d.idx = 5'd0;
					if (q.wd[7:0] == HOP_TCAL)
					begin
						d.code = CMD_RD_WORD; // [RQ10]
						d.a1 = REG_THERM;
					end
					else if (q.wd[7:0] == HOP_RESTORE)
					begin
						d.code = CMD_WR_WORD; // [RQ11]
						d.a1 = REG_DELIM;
						d.wdat = DELIM_FACTORY;
					end
					else
					begin
						d.code = q.wd[7:0];
						d.a1 = q.wd[15:8];
						d.wdat = q.wd[31:16];
					end
					d.tx = d.code;
					d.last = tx_last(d.code);
				end
			end
			else if (q.wa >= ADDR_W'(OFS_DATA0) && q.wa <= ADDR_W'(OFS_DATA3)
				&& q.wa[1:0] == 2'b00)
			begin
				for (int k = 0; k < 4; k++)
				begin
					if (q.ws[k])
					begin
						d.buff[4'({wi[1:0] - 2'd2, 2'b00}) + 4'(3 - k)] = q.wd[8*k +: 8];
					end
				end
			end
			else if (q.wa != ADDR_W'(OFS_STAT))
			begin
				d.bresp = 2'b10;
			end
		end
		unique case (q.st)
			H_IDLE:
			begin
			end
			H_TX:
			begin
				if (link.h2d_ready)
				begin
					d.idx = n;
					if (q.idx == q.last)
					begin
						d.st = H_RX;
						d.idx = 5'd0;
						d.sum = 8'h00;
						d.last = rx_last(q.code);
					end
					else if (n == 5'd1)
					begin
						d.tx = q.a1;
					end
					else if (q.code == CMD_PAGE_WR)
					begin
						d.tx = q.buff[4'(n - 5'd2)];
					end
					else
					begin
						d.tx = (n == 5'd2) ? q.wdat[15:8] : q.wdat[7:0];
					end
				end
			end
			H_RX:
			begin
				if (link.d2h_valid)
				begin
					d.idx = n;
					d.sum = q.sum + b;
					if (q.idx == 5'd0)
					begin
						d.ack = (b == RSP_ACK);
						d.cks_bad = 1'b0;
						done = (b != RSP_ACK) || (q.last == 5'd0);
					end
					else if (q.idx == q.last)
					begin
						d.cks_bad = (b != q.sum); // [RQ13]
						done = 1'b1;
					end
					else
					begin
						d.buff[4'(q.idx - 5'd1)] = b;
					end
				end
			end
			default:
			begin
				d.st = H_IDLE;
			end
		endcase
		if (done)
		begin
			d.st = H_IDLE;
			if (q.code == CMD_AUTO_FREQ)
			begin
				d.cal_ok = d.ack; // [RQ4]
			end
			if (q.code == CMD_SAVE)
			begin
				d.cal_ok = 1'b0;
			end
			if (!q.phase && d.ack && !d.cks_bad && (q.mac == HOP_TCAL || q.mac == HOP_RESTORE))
			begin
				d.phase = 1'b1;
				d.st = H_TX;
				d.idx = 5'd0;
				d.code = (q.mac == HOP_TCAL) ? CMD_WR_WORD : CMD_SAVE; // [RQ10] [RQ11]
				d.a1 = REG_TCAL;
				d.wdat = {q.buff[0], q.buff[1]};
				d.tx = d.code;
				d.last = tx_last(d.code);
			end
		end
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			q <= '0;
		end
		else
		begin
			q <= d;
		end
	end

	assign awready = !q.aw_got && !q.bvalid;
	assign wready = !q.w_got && !q.bvalid;
	assign bvalid = q.bvalid;
	assign bresp = q.bresp;
	assign arready = !q.rvalid;
	assign rvalid = q.rvalid;
	assign rdata = q.rdata;
	assign rresp = q.rresp;
	assign link.h2d_valid = (q.st == H_TX);
	assign link.h2d_data = q.tx;
	assign link.d2h_ready = (q.st == H_RX);
endmodule

/* File: test/link_props.sv */
// assertions on the command byte link between host and device ends
`timescale 1ns/1ps
module link_props (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic h2d_valid,
	input wire logic h2d_ready,
	input wire cal_pkg::byte_t h2d_data,
	input wire logic d2h_valid,
	input wire logic d2h_ready,
	input wire cal_pkg::byte_t d2h_data
);
	import cal_pkg::*;
	// ********
	// byte tracking
	// ********
	logic seen_q;
	logic [4:0] args_q;
	logic [4:0] rsp_q;
	byte_t op_q;
	byte_t page_q;
	byte_t sum_q;
	// an opcode is the first byte taken after an answer, so args never pose as codes
	wire h_tk = h2d_valid && h2d_ready;
	wire d_tk = d2h_valid && d2h_ready;
	wire op_tk = h_tk && seen_q;
	wire first = d2h_valid && rsp_q == 5'h0;
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			seen_q <= 1'b1;
			args_q <= 5'h0;
			rsp_q <= 5'h0;
			op_q <= 8'h00;
			page_q <= 8'h00;
			sum_q <= 8'h00;
		end
		else
		begin
			if (op_tk)
			begin
				op_q <= h2d_data;
				seen_q <= 1'b0;
				args_q <= 5'h0;
				rsp_q <= 5'h0;
				sum_q <= 8'h00;
			end
			else if (h_tk)
			begin
				args_q <= args_q + 5'h1;
				if (args_q == 5'h0)
					page_q <= h2d_data;
			end
			if (d_tk)
			begin
				seen_q <= 1'b1;
				rsp_q <= rsp_q + 5'h1;
				sum_q <= sum_q + d2h_data;
			end
		end
	end
	// ********
	// properties
	// ********
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	a_rsp_hold: assert property (d2h_valid && !d2h_ready |=> d2h_valid && $stable(d2h_data))
		else $error("answer byte dropped or changed");
	a_req_hold: assert property (h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_data))
		else $error("command byte dropped or changed");
	a_erase_ack: assert property (op_tk && h2d_data == CMD_ERASE |-> ##[2:300] (d2h_valid && d2h_data == RSP_ACK))
		else $error("erase not acknowledged");
	a_erase_noarg: assert property (first && op_q == CMD_ERASE |-> args_q == 5'h0)
		else $error("erase read operands");
	a_rd_ack: assert property (first && op_q == CMD_PAGE_RD && page_q < 32 |-> args_q == 5'h1 && d2h_data == RSP_ACK)
		else $error("page read not acknowledged");
	a_rd_bad_page: assert property (first && op_q == CMD_PAGE_RD && page_q >= 32 |-> d2h_data == RSP_NAK)
		else $error("bad page read accepted");
	a_wr_len: assert property (first && op_q == CMD_PAGE_WR && d2h_data == RSP_ACK |-> args_q == 5'h11 && page_q < 32)
		else $error("page write ack with wrong length");
	a_wr_bad_page: assert property (first && op_q == CMD_PAGE_WR && page_q >= 32 |-> d2h_data == RSP_NAK)
		else $error("bad page write accepted");
	a_rd_sum: assert property (d_tk && op_q == CMD_PAGE_RD && rsp_q == 5'h11 |-> d2h_data == sum_q)
		else $error("page read checksum wrong");
	a_rd_count: assert property (op_tk && op_q == CMD_PAGE_RD && page_q < 32 |-> rsp_q == 5'h12)
		else $error("page read answer length wrong");
	a_rsp_taken: assert property (d2h_valid |-> d2h_ready)
		else $error("answer byte offered while host not listening");
	a_req_taken: assert property (h2d_valid |-> h2d_ready)
		else $error("command byte offered while device not listening");
endmodule

/* File: test/testbench.sv */
// self-checking bench joining host and device ends over the command link
`timescale 1ns/1ps
module testbench;
	import cal_pkg::*;
	logic core_clk, reset_n, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, ref_applied, dc_mode, flash_save;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, st;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [9:0] therm_adc;
	word_t freq_raw, irms_raw, pact_raw, preact_raw, flash_gain, flash_delim;
	word_t freq_out, irms_out, pact_out, preact_out, save_gain, save_delim;
	int n_mismatch = 0;
	int checked = 0;
	int saves = 0;
	cal_link_if link();
	calib_host_ctrl calib_host_ctrl_i(.core_clk, .reset_n, .awvalid, .awready, .awaddr,
		.wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
		.araddr, .rvalid, .rready, .rdata, .rresp, .ref_applied, .link);
	calib_eeprom_cmd_handler calib_eeprom_cmd_handler_i(.core_clk, .reset_n, .link,
		.freq_raw, .irms_raw, .pact_raw, .preact_raw, .therm_adc, .dc_mode, .flash_gain,
		.flash_delim, .freq_out, .irms_out, .pact_out, .preact_out, .flash_save,
		.save_gain, .save_delim);
	link_props link_props_i(.core_clk, .reset_n, .h2d_valid(link.h2d_valid),
		.h2d_ready(link.h2d_ready), .h2d_data(link.h2d_data), .d2h_valid(link.d2h_valid),
		.d2h_ready(link.d2h_ready), .d2h_data(link.d2h_data));
	// ********
	// clock, flash store, watchdog
	// ********
	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	// flash keeps what the device saves, so a later reset shows what was stored
	always @(posedge core_clk)
	begin
		if (flash_save === 1'b1)
		begin
			flash_gain <= save_gain;
			flash_delim <= save_delim;
			saves <= saves + 1;
		end
	end
	initial
	begin
		#2000000;
		n_mismatch++;
		final_report;
	end
	// ********
	// shared tasks
	// ********
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report;
		if (n_mismatch == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic do_reset;
		@(posedge core_clk);
		reset_n <= 1'b0;
		repeat (5) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge core_clk);
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		bready <= 1'b1;
		do
		begin
			@(posedge core_clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a);
		@(posedge core_clk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do
		begin
			@(posedge core_clk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		st = rdata;
		rready <= 1'b0;
	endtask
	task automatic cmd(input byte_t op, input byte_t arg, input word_t w);
		axi_wr(OFS_CMD, {w, arg, op});
		do
			axi_rd(OFS_STAT);
		while (st[0] !== 1'b0);
	endtask
	function automatic logic [31:0] pat(input byte_t p, input int k);
		return {p, 8'(k), ~p, 8'h3C};
	endfunction
	task automatic wr_page(input byte_t p);
		for (int k = 0; k < 4; k++)
			axi_wr(OFS_DATA0 + 8'(4 * k), pat(p, k));
		cmd(CMD_PAGE_WR, p, 16'h0000);
	endtask
	task automatic rd_page(input byte_t p, input bit erased);
		cmd(CMD_PAGE_RD, p, 16'h0000);
		check(st[3:1], 3'h1);
		for (int k = 0; k < 4; k++)
		begin
			axi_rd(OFS_DATA0 + 8'(4 * k));
			check(st, erased ? 32'hFFFFFFFF : pat(p, k));
		end
	endtask
	// ********
	// scenarios
	// ********
	task automatic t_eeprom;
		cmd(CMD_ERASE, 8'h00, 16'h0000);
		check(st[1], 1'b1);
		rd_page(8'd0, 1'b1);
		rd_page(8'd31, 1'b1);
		wr_page(8'd5);
		check(st[1], 1'b1);
		wr_page(8'd31);
		check(st[1], 1'b1);
		rd_page(8'd5, 1'b0);
		rd_page(8'd31, 1'b0);
		rd_page(8'd6, 1'b1);
		cmd(CMD_PAGE_RD, 8'd32, 16'h0000);
		check(st[1], 1'b0);
		wr_page(8'd32);
		check(st[1], 1'b0);
		rd_page(8'd0, 1'b1);
		axi_wr(8'h40, 32'h0);
		check(bresp, 2'h2);
		axi_rd(8'h40);
		check(rresp, 2'h2);
	endtask
	task automatic t_comp;
		therm_adc <= 10'h040;
		cmd(CMD_WR_WORD, REG_COEF_I, 16'h2000);
		cmd(CMD_WR_WORD, REG_COEF_P, 16'hE000);
		cmd(CMD_WR_WORD, REG_COEF_F, 16'h2000);
		repeat (3) @(posedge core_clk);
		check(irms_out, 16'h4040);
		check(pact_out, 16'h3FC0);
		check(preact_out, 16'h3FC0);
		check(freq_out, 16'h4080);
		dc_mode <= 1'b1;
		repeat (3) @(posedge core_clk);
		check(freq_out, 16'h0000);
		dc_mode <= 1'b0;
		cmd(HOP_TCAL, 8'h00, 16'h0000);
		repeat (3) @(posedge core_clk);
		check(irms_out, 16'h4000);
		check(pact_out, 16'h4000);
		cmd(CMD_WR_WORD, REG_THERM, 16'h1234);
		check(st[1], 1'b0);
		cmd(CMD_RD_WORD, 8'h08, 16'h0000);
		axi_rd(OFS_DATA0);
		check(st[31:16], 16'h4000);
	endtask
	task automatic t_cal;
		int s0;
		// autocal without the reference present must be held back by the host
		ref_applied <= 1'b0;
		cmd(CMD_AUTO_FREQ, 8'h00, 16'h0000);
		check(st[2], 1'b1);
		ref_applied <= 1'b1;
		// gain stays unity until here, so measured equals the raw input
		freq_raw <= 16'd60000;
		cmd(CMD_AUTO_FREQ, 8'h00, 16'h0000);
		check(st[1], 1'b0);
		check(save_gain, 16'h8000);
		s0 = saves;
		cmd(CMD_SAVE, 8'h00, 16'h0000);
		check(st[2], 1'b1);
		check(saves, s0);
		freq_raw <= 16'd4000;
		cmd(CMD_AUTO_FREQ, 8'h00, 16'h0000);
		check(st[1], 1'b1);
		check(save_gain, 16'hC000);
		cmd(CMD_SAVE, 8'h00, 16'h0000);
		check(saves, s0 + 1);
		do_reset;
		check(save_gain, 16'hC000);
		cmd(HOP_RESTORE, 8'h00, 16'h0000);
		check(flash_delim, DELIM_FACTORY);
		do_reset;
		check(save_gain, 16'h8000);
	endtask
	// ********
	// main sequence
	// ********
	initial
	begin
		{reset_n, awvalid, wvalid, bready, arvalid, rready, dc_mode} = 7'h00;
		{awaddr, araddr, wdata} = 48'h0;
		wstrb = 4'hF;
		ref_applied = 1'b1;
		therm_adc = 10'h000;
		{freq_raw, irms_raw, pact_raw, preact_raw} = {4{16'h4000}};
		flash_gain = 16'h8000;
		flash_delim = 16'h0000;
		do_reset;
		t_eeprom;
		t_comp;
		t_cal;
		final_report;
	end
endmodule
